/* File: common/cipher_seq_regs.svh */
/*
 * Register offsets, reset values and timing counts of the cipher data
 * sequencer. Assumes a byte-addressed register interface with 32-bit data.
 */
// Behaviour
// - Encrypt count write loads remaining encrypt count.
// - Nonzero encrypt count write starts encrypt input valid.
// - Each plain block issued advances plain address.
// - Each plain block issued decrements encrypt count.
// - Encrypt input accepted presents next plain block.
// - Encrypt count zero at accept ends run.
// - Encrypt run clears plain address first.
// - Encrypt run clears cipher address first.
// - Valid encrypt output is written to cipher RAM.
// - Each stored cipher result advances cipher address.
// - RAM read data arrives two cycles late.
// - Decrypt count write loads remaining decrypt count.
// - Nonzero decrypt count write starts decrypt input valid.
// - Each cipher block issued advances cipher address.
// - Each cipher block issued decrements decrypt count.
// - Decrypt input accepted presents next cipher block.
// - Decrypt count zero at accept ends run.
// - Decrypt run clears cipher address first.
// - Decrypt run clears plain address first.
// - Valid decrypt output is written to plain RAM.
// - Each stored plain result advances plain address.
`ifndef CIPHER_SEQ_REGS_SVH
`define CIPHER_SEQ_REGS_SVH
`define ENC_CNT_OFS 16'h0008
`define DEC_CNT_OFS 16'h000c
`define CNT_RST 32'h0000_0000
`define ADDR_RST 10'h000
`define RAM_RD_LAT 2'h2
`endif

/* File: common/cipher_seq_pkg.sv */
/*
 * Types of the cipher data sequencer: state encoding and register images.
 * Assumes the constants header is included by the design files.
 */
package cipher_seq_pkg;
    typedef logic [9:0] ram_addr_t;
    typedef logic [127:0] block_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_BUSY = 3'b100
    } seq_state_t;

    typedef struct packed {
        seq_state_t state;
        logic dec_mode;
        logic [1:0] lat_cnt;
        logic [31:0] enc_cnt;
        logic [31:0] dec_cnt;
        ram_addr_t plain_addr;
        ram_addr_t cipher_addr;
        logic enc_valid;
        logic dec_valid;
        block_t blk_data;
        logic plain_we;
        logic cipher_we;
        block_t wr_data;
        logic [31:0] rd_data;
    } seq_regs_t;

    typedef struct packed {
        logic [1:0] count;
        logic s_ready;
        logic [128:0] ent0;
        logic [128:0] ent1;
    } buf_regs_t;
endpackage

/* File: hdl/result_buffer2.sv */
/*
 * Two-entry buffer for core results on their way to the RAMs.
 * Assumes source and sink share the clock; entry 0 is the head.
 */
`timescale 1ns/1ps
module result_buffer2 (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_s_valid,
    input wire logic [128:0] i_s_data,
    output logic o_s_ready,
    output logic o_m_valid,
    output logic [128:0] o_m_data,
    input wire logic i_m_ready
);
    import cipher_seq_pkg::*;

    buf_regs_t r_reg;
    buf_regs_t r_next;
    logic push;
    logic pop;

    // Push and pop, with the head shifting forward on a pop.
    always_comb begin
        r_next = r_reg;
        push = i_s_valid && r_reg.s_ready;
        pop = i_m_ready && (r_reg.count != 2'h0);
        if (pop) begin
            r_next.ent0 = r_reg.ent1;
        end
        if (push) begin
            if (r_reg.count == 2'h0 || (r_reg.count == 2'h1 && pop)) begin
                r_next.ent0 = i_s_data;
            end else begin
                r_next.ent1 = i_s_data;
            end
        end
        r_next.count = r_reg.count + {1'b0, push} - {1'b0, pop};
        r_next.s_ready = (r_next.count != 2'h2);
    end

    // State register.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= '{count: 2'h0, s_ready: 1'b1, ent0: '0, ent1: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_s_ready = r_reg.s_ready;
    assign o_m_valid = (r_reg.count != 2'h0);
    assign o_m_data = r_reg.ent0;
endmodule // result_buffer2

/* File: hdl/cipher_data_sequencer.sv */
/*
 * Sequencer that feeds RAM blocks to the encrypt and decrypt cores and
 * stores their results. Assumes cores and RAMs on the same clock, RAMs
 * with a read latency of two cycles, and one run active at a time.
 */
`timescale 1ns/1ps
`include "cipher_seq_regs.svh"
module cipher_data_sequencer (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [15:0] i_regif_addr,
    input wire logic [31:0] i_regif_write_data,
    input wire logic i_regif_wr_en,
    output logic [31:0] o_regif_read_data,
    output cipher_seq_pkg::ram_addr_t o_plain_ram_addr,
    output logic o_plain_ram_we,
    output cipher_seq_pkg::block_t o_plain_ram_wdata,
    input wire cipher_seq_pkg::block_t i_plain_ram_rdata,
    output cipher_seq_pkg::ram_addr_t o_cipher_ram_addr,
    output logic o_cipher_ram_we,
    output cipher_seq_pkg::block_t o_cipher_ram_wdata,
    input wire cipher_seq_pkg::block_t i_cipher_ram_rdata,
    output logic o_enc_input_valid,
    output cipher_seq_pkg::block_t o_enc_input_data,
    input wire logic i_enc_input_accepted,
    input wire logic i_enc_output_valid,
    input wire cipher_seq_pkg::block_t i_enc_output,
    output logic o_dec_input_valid,
    output cipher_seq_pkg::block_t o_dec_input_data,
    input wire logic i_dec_input_accepted,
    input wire logic i_dec_output_valid,
    input wire cipher_seq_pkg::block_t i_dec_output,
    output logic o_result_ready
);
    import cipher_seq_pkg::*;

    seq_regs_t r_reg;
    seq_regs_t r_next;
    logic enc_start;
    logic dec_start;
    logic res_valid;
    logic [128:0] res_data;
    logic drain_ready;
    logic buf_s_ready;
    logic buf_m_valid;
    logic [128:0] buf_m_data;

    // Decodes a register write to one offset.
    function automatic logic wr_hit(input logic [15:0] ofs);
        return i_regif_wr_en && (i_regif_addr == ofs);
    endfunction

    // A count write of zero starts nothing and only loads the count.
    assign enc_start = wr_hit(`ENC_CNT_OFS) && (i_regif_write_data != '0);
    assign dec_start = wr_hit(`DEC_CNT_OFS) && (i_regif_write_data != '0);

    // Writes stall while a start clears the pointers and while the previous
    // write still has to advance its pointer.
    assign drain_ready = !enc_start && !dec_start
        && !r_reg.plain_we && !r_reg.cipher_we;

    // Results of either core enter the buffer tagged with their RAM.
    always_comb begin
        res_valid = i_enc_output_valid || i_dec_output_valid;
        res_data = {1'b0, i_enc_output};
        if (i_dec_output_valid) begin
            res_data = {1'b1, i_dec_output};
        end
    end

    result_buffer2 u_res_buf (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_s_valid(res_valid),
        .i_s_data(res_data),
        .o_s_ready(buf_s_ready),
        .o_m_valid(buf_m_valid),
        .o_m_data(buf_m_data),
        .i_m_ready(drain_ready)
    );

    // Next state of the whole sequencer.
    always_comb begin
        r_next = r_reg;
        r_next.enc_valid = 1'b0;
        r_next.dec_valid = 1'b0;
        r_next.plain_we = 1'b0;
        r_next.cipher_we = 1'b0;
        // Register read shows the remaining counts.
        case (i_regif_addr)
            `ENC_CNT_OFS: r_next.rd_data = r_reg.enc_cnt;
            `DEC_CNT_OFS: r_next.rd_data = r_reg.dec_cnt;
            default: r_next.rd_data = '0;
        endcase
        // A finished write advances the pointer it used.
        if (r_reg.plain_we) begin
            r_next.plain_addr = r_reg.plain_addr + 10'h001;
        end
        if (r_reg.cipher_we) begin
            r_next.cipher_addr = r_reg.cipher_addr + 10'h001;
        end
        // Buffered result goes to the RAM its core writes.
        if (buf_m_valid && drain_ready) begin
            r_next.wr_data = buf_m_data[127:0];
            if (buf_m_data[128]) begin
                r_next.plain_we = 1'b1;
            end else begin
                r_next.cipher_we = 1'b1;
            end
        end
        // A nonzero count restarts from the first block.
        if (enc_start || dec_start) begin
            r_next.dec_mode = dec_start;
            r_next.plain_addr = `ADDR_RST;
            r_next.cipher_addr = `ADDR_RST;
            r_next.lat_cnt = `RAM_RD_LAT;
            r_next.state = ST_WAIT;
        end else begin
            case (r_reg.state)
                ST_IDLE: begin
                    r_next.state = ST_IDLE;
                end
                ST_WAIT: begin
                    if (r_reg.lat_cnt != 2'h0) begin
                        r_next.lat_cnt = r_reg.lat_cnt - 2'h1;
                    end else if (buf_s_ready) begin
                        // Read data of the current address is valid now.
                        r_next.state = ST_BUSY;
                        if (r_reg.dec_mode) begin
                            r_next.blk_data = i_cipher_ram_rdata;
                            r_next.dec_valid = 1'b1;
                            r_next.cipher_addr =
                                r_reg.cipher_addr + 10'h001;
                            r_next.dec_cnt = r_reg.dec_cnt - 32'h1;
                        end else begin
                            r_next.blk_data = i_plain_ram_rdata;
                            r_next.enc_valid = 1'b1;
                            r_next.plain_addr =
                                r_reg.plain_addr + 10'h001;
                            r_next.enc_cnt = r_reg.enc_cnt - 32'h1;
                        end
                    end
                end
                ST_BUSY: begin
                    if (!r_reg.dec_mode && i_enc_input_accepted) begin
                        if (r_reg.enc_cnt != '0) begin
                            r_next.state = ST_WAIT;
                            r_next.lat_cnt = `RAM_RD_LAT;
                        end else begin
                            r_next.state = ST_IDLE;
                        end
                    end
                    if (r_reg.dec_mode && i_dec_input_accepted) begin
                        if (r_reg.dec_cnt != '0) begin
                            r_next.state = ST_WAIT;
                            r_next.lat_cnt = `RAM_RD_LAT;
                        end else begin
                            r_next.state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    r_next.state = ST_IDLE;
                end
            endcase
        end
        // Count loads come last, so a write wins over an issue decrement.
        if (wr_hit(`ENC_CNT_OFS)) begin
            r_next.enc_cnt = i_regif_write_data;
        end
        if (wr_hit(`DEC_CNT_OFS)) begin
            r_next.dec_cnt = i_regif_write_data;
        end
    end

    // State register.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= '{state: ST_IDLE, dec_mode: 1'b0, lat_cnt: 2'h0,
                enc_cnt: `CNT_RST, dec_cnt: `CNT_RST,
                plain_addr: `ADDR_RST, cipher_addr: `ADDR_RST,
                enc_valid: 1'b0, dec_valid: 1'b0, blk_data: '0,
                plain_we: 1'b0, cipher_we: 1'b0, wr_data: '0,
                rd_data: 32'h0};
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs come straight from the state register; result ready from the buffer's.
    assign o_regif_read_data = r_reg.rd_data;
    assign o_plain_ram_addr = r_reg.plain_addr;
    assign o_plain_ram_we = r_reg.plain_we;
    assign o_plain_ram_wdata = r_reg.wr_data;
    assign o_cipher_ram_addr = r_reg.cipher_addr;
    assign o_cipher_ram_we = r_reg.cipher_we;
    assign o_cipher_ram_wdata = r_reg.wr_data;
    assign o_enc_input_valid = r_reg.enc_valid;
    assign o_enc_input_data = r_reg.blk_data;
    assign o_dec_input_valid = r_reg.dec_valid;
    assign o_dec_input_data = r_reg.blk_data;
    assign o_result_ready = buf_s_ready;

    // Checks on the sequencing, all in the system clock domain.
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    // Start edge followed by the read latency and the issue.
    sequence s_enc_start;
        enc_start && !dec_start;
    endsequence
    sequence s_dec_start;
        dec_start && !enc_start;
    endsequence
    sequence s_enc_issue;
        !o_enc_input_valid [*3] ##[1:40] o_enc_input_valid;
    endsequence

    property p_enc_load;
        wr_hit(`ENC_CNT_OFS) |=> r_reg.enc_cnt == $past(i_regif_write_data);
    endproperty
    a_enc_load: assert property (p_enc_load)
        else $error("Encrypt count not loaded.");

    property p_dec_load;
        wr_hit(`DEC_CNT_OFS) |=> r_reg.dec_cnt == $past(i_regif_write_data);
    endproperty
    a_dec_load: assert property (p_dec_load)
        else $error("Decrypt count not loaded.");

    property p_enc_start;
        s_enc_start ##1 (!enc_start && !dec_start) [*4] |-> ##[0:36]
            o_enc_input_valid;
    endproperty
    a_enc_start: assert property (p_enc_start)
        else $error("Encrypt run did not issue its first block.");

    property p_enc_latency;
        s_enc_start |=> s_enc_issue;
    endproperty
    a_enc_latency: assert property (p_enc_latency)
        else $error("Encrypt block issued before read latency.");

    property p_ptr_clear;
        (s_enc_start or s_dec_start) |=>
            o_plain_ram_addr == `ADDR_RST && o_cipher_ram_addr == `ADDR_RST;
    endproperty
    a_ptr_clear: assert property (p_ptr_clear)
        else $error("Run started without clearing RAM addresses.");

    property p_enc_step;
        o_enc_input_valid |-> o_plain_ram_addr ==
            $past(o_plain_ram_addr) + 10'h001
            && r_reg.enc_cnt == $past(r_reg.enc_cnt) - 32'h1;
    endproperty
    a_enc_step: assert property (p_enc_step)
        else $error("Encrypt issue did not step address and count.");

    property p_dec_step;
        o_dec_input_valid |-> o_cipher_ram_addr ==
            $past(o_cipher_ram_addr) + 10'h001
            && r_reg.dec_cnt == $past(r_reg.dec_cnt) - 32'h1;
    endproperty
    a_dec_step: assert property (p_dec_step)
        else $error("Decrypt issue did not step address and count.");

    property p_enc_align;
        o_enc_input_valid |-> o_enc_input_data == $past(i_plain_ram_rdata);
    endproperty
    a_enc_align: assert property (p_enc_align)
        else $error("Encrypt block not aligned with read data.");

    property p_dec_align;
        o_dec_input_valid |-> o_dec_input_data == $past(i_cipher_ram_rdata);
    endproperty
    a_dec_align: assert property (p_dec_align)
        else $error("Decrypt block not aligned with read data.");

    property p_enc_end;
        r_reg.state == ST_BUSY && !r_reg.dec_mode && i_enc_input_accepted
            && r_reg.enc_cnt == '0 && !enc_start && !dec_start
            |=> (r_reg.state == ST_IDLE && !o_enc_input_valid);
    endproperty
    a_enc_end: assert property (p_enc_end)
        else $error("Encrypt run did not end at count zero.");

    property p_dec_end;
        r_reg.state == ST_BUSY && r_reg.dec_mode && i_dec_input_accepted
            && r_reg.dec_cnt == '0 && !enc_start && !dec_start
            |=> (r_reg.state == ST_IDLE && !o_dec_input_valid);
    endproperty
    a_dec_end: assert property (p_dec_end)
        else $error("Decrypt run did not end at count zero.");

    property p_enc_next;
        r_reg.state == ST_BUSY && !r_reg.dec_mode && i_enc_input_accepted
            && r_reg.enc_cnt != '0 && !enc_start && !dec_start
            |=> r_reg.state == ST_WAIT && r_reg.lat_cnt == `RAM_RD_LAT;
    endproperty
    a_enc_next: assert property (p_enc_next)
        else $error("Encrypt accept did not fetch the next block.");

    property p_cipher_wr;
        o_cipher_ram_we |=> o_cipher_ram_addr ==
            $past(o_cipher_ram_addr) + 10'h001;
    endproperty
    a_cipher_wr: assert property (p_cipher_wr)
        else $error("Cipher address not advanced after write.");

    property p_plain_wr;
        o_plain_ram_we && !enc_start && !dec_start |=> o_plain_ram_addr ==
            $past(o_plain_ram_addr) + 10'h001;
    endproperty
    a_plain_wr: assert property (p_plain_wr)
        else $error("Plain address not advanced after write.");

    property p_enc_store;
        i_enc_output_valid && !i_dec_output_valid && o_result_ready
            && !r_reg.plain_we |-> ##[1:12] o_cipher_ram_we;
    endproperty
    a_enc_store: assert property (p_enc_store)
        else $error("Encrypt result never written to cipher RAM.");

    property p_dec_store;
        i_dec_output_valid && o_result_ready && !r_reg.cipher_we
            |-> ##[1:12] o_plain_ram_we;
    endproperty
    a_dec_store: assert property (p_dec_store)
        else $error("Decrypt result never written to plain RAM.");

    property p_dec_start;
        s_dec_start ##1 (!enc_start && !dec_start) [*4] |-> ##[0:36]
            o_dec_input_valid;
    endproperty
    a_dec_start: assert property (p_dec_start)
        else $error("Decrypt run did not issue its first block.");

    property p_dec_next;
        r_reg.state == ST_BUSY && r_reg.dec_mode && i_dec_input_accepted
            && r_reg.dec_cnt != '0 && !enc_start && !dec_start
            |=> r_reg.state == ST_WAIT;
    endproperty
    a_dec_next: assert property (p_dec_next)
        else $error("Decrypt accept did not fetch the next block.");
endmodule // cipher_data_sequencer

/* File: bench/core_ram_stubs.sv */
/*
 * Far side of the cipher data sequencer: a RAM with a two-cycle read
 * latency and a cipher core that XORs a fixed key into each block.
 * Assumes one clock shared with the sequencer.
 */
`timescale 1ns/1ps
module ram_stub (
    input wire logic i_clk_sys,
    input wire cipher_seq_pkg::ram_addr_t i_addr,
    input wire logic i_we,
    input wire cipher_seq_pkg::block_t i_wdata,
    output cipher_seq_pkg::block_t o_rdata
);
    import cipher_seq_pkg::*;
    block_t mem [0:1023];
    block_t stage;
    // Two register stages give the read latency of two cycles.
    always @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        stage <= mem[i_addr];
        o_rdata <= stage;
    end
endmodule // ram_stub

module core_stub #(
    parameter logic [127:0] KEY = 128'h5a5a_0f0f_3c3c_a5a5_1234_8765_c3c3_9696
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_slow,
    input wire logic i_valid,
    input wire logic [127:0] i_data,
    output logic o_accepted,
    output logic o_out_valid,
    output logic [127:0] o_out
);
    logic [127:0] res;
    int cnt;
    // A taken block yields its result, then an accept one cycle later.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 0;
            res <= '0;
            o_accepted <= 1'b0;
            o_out_valid <= 1'b0;
        end else begin
            o_accepted <= (cnt == 1);
            o_out_valid <= (cnt == 2);
            if (i_valid) begin
                res <= i_data ^ KEY;
                cnt <= i_slow ? 14 : 4;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
    // Outside its pulse the result bus shows no stale value.
    assign o_out = o_out_valid ? res : ~res;
endmodule // core_stub

/* File: bench/tb_top.sv */
/*
 * Self-checking bench of the cipher data sequencer with RAM and core stubs.
 * Assumes the stubs file is compiled first and a 50 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
    import cipher_seq_pkg::*;
    localparam logic [127:0] KEY = 128'h0123_4567_89ab_cdef_f0e1_d2c3_b4a5_9687;
    logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, slow = 1'b0;
    logic [15:0] addr = '0;
    logic [31:0] wdata = '0, rd32;
    ram_addr_t p_addr, c_addr;
    block_t p_wd, p_rd, c_wd, c_rd, ed, eo, dd, dout;
    logic p_we, c_we, ev, ea, eov, dv, da, dov, rr;
    int err_count = 0, n_tests = 0;
    int enc_iss, enc_wr, dec_iss, dec_wr;
    block_t g_plain [0:15];
    block_t g_cipher [0:15];

    // The clock toggles every half period of 10 ns.
    always #10 clk = ~clk;

    cipher_data_sequencer DUT (.i_clk_sys(clk), .i_rst(rst),
        .i_regif_addr(addr), .i_regif_write_data(wdata),
        .i_regif_wr_en(wr_en), .o_regif_read_data(rd32),
        .o_plain_ram_addr(p_addr), .o_plain_ram_we(p_we),
        .o_plain_ram_wdata(p_wd), .i_plain_ram_rdata(p_rd),
        .o_cipher_ram_addr(c_addr), .o_cipher_ram_we(c_we),
        .o_cipher_ram_wdata(c_wd), .i_cipher_ram_rdata(c_rd),
        .o_enc_input_valid(ev), .o_enc_input_data(ed),
        .i_enc_input_accepted(ea), .i_enc_output_valid(eov),
        .i_enc_output(eo), .o_dec_input_valid(dv), .o_dec_input_data(dd),
        .i_dec_input_accepted(da), .i_dec_output_valid(dov),
        .i_dec_output(dout), .o_result_ready(rr));
    ram_stub PR (.i_clk_sys(clk), .i_addr(p_addr), .i_we(p_we),
        .i_wdata(p_wd), .o_rdata(p_rd));
    ram_stub CR (.i_clk_sys(clk), .i_addr(c_addr), .i_we(c_we),
        .i_wdata(c_wd), .o_rdata(c_rd));
    core_stub #(.KEY(KEY)) EC (.i_clk_sys(clk), .i_rst(rst), .i_slow(slow),
        .i_valid(ev), .i_data(ed), .o_accepted(ea), .o_out_valid(eov),
        .o_out(eo));
    core_stub #(.KEY(KEY)) DC (.i_clk_sys(clk), .i_rst(rst), .i_slow(slow),
        .i_valid(dv), .i_data(dd), .o_accepted(da), .o_out_valid(dov),
        .o_out(dout));

    // Compares one value and counts the outcome.
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp,
                       input string msg);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
                     seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One register write, strobe high for a single edge.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    // Presents an address and checks the registered read data.
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        chk(rd32, exp, "read data");
    endtask

    // Every issue and every RAM write is checked against the golden copy.
    always @(posedge clk) begin
        if (!rst && ev) begin
            chk(ed, g_plain[enc_iss], "enc block");
            chk(p_addr, enc_iss + 1, "plain addr after issue");
            enc_iss++;
        end
        if (!rst && c_we) begin
            chk(c_addr, enc_wr, "cipher write addr");
            chk(c_wd, g_plain[enc_wr] ^ KEY, "cipher write data");
            enc_wr++;
        end
        if (!rst && dv) begin
            chk(dd, g_cipher[dec_iss], "dec block");
            chk(c_addr, dec_iss + 1, "cipher addr after issue");
            dec_iss++;
        end
        if (!rst && p_we) begin
            chk(p_addr, dec_wr, "plain write addr");
            chk(p_wd, g_cipher[dec_wr] ^ KEY, "plain write data");
            dec_wr++;
        end
    end

    // Loads fresh random blocks into both RAMs and the golden copies.
    task automatic preload;
        for (int i = 0; i < 16; i++) begin
            g_plain[i] = {$urandom, $urandom, $urandom, $urandom};
            g_cipher[i] = {$urandom, $urandom, $urandom, $urandom};
            PR.mem[i] = g_plain[i];
            CR.mem[i] = g_cipher[i];
        end
        enc_iss = 0;
        enc_wr = 0;
        dec_iss = 0;
        dec_wr = 0;
    endtask

    // Starts one run of n blocks and checks its course and its end.
    task automatic run(input logic dec, input int n, input logic slw);
        int t;
        logic [15:0] a;
        a = dec ? 16'h000c : 16'h0008;
        preload();
        slow = slw;
        wr(a, n);
        @(negedge clk);
        chk(rd32, n, "count loaded");
        for (t = 0; t < 3000 && (dec ? dec_wr : enc_wr) < n; t++) begin
            @(negedge clk);
        end
        if (t == 3000) begin
            err_count++;
            $display("mismatch at %0t: run did not finish", $time);
            close_out();
        end
        repeat (40) @(negedge clk);
        chk(dec ? dec_iss : enc_iss, n, "issue count");
        chk(dec ? dec_wr : enc_wr, n, "result count");
        chk(dec ? enc_iss : dec_iss, 0, "other core idle");
        rd(a, 0);
        for (int i = 0; i <= n; i++) begin
            if (dec) begin
                chk(PR.mem[i], i < n ? g_cipher[i] ^ KEY : g_plain[i],
                    "plain ram");
            end else begin
                chk(CR.mem[i], i < n ? g_plain[i] ^ KEY : g_cipher[i],
                    "cipher ram");
            end
        end
        $display("test run dec=%0d n=%0d slow=%0d done", dec, n, slw);
    endtask

    // Main sequence: reset, register checks, then a series of runs.
    initial begin
        void'($urandom(32'h57e9f4d1));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(rr, 1'b1, "result ready after reset");
        rd(16'h0008, 0);
        rd(16'h000c, 0);
        $display("test reset done");
        run(1'b0, 1, 1'b0);
        run(1'b1, 1, 1'b1);
        run(1'b0, 8, 1'b0);
        run(1'b1, 8, 1'b0);
        for (int k = 0; k < 4; k++) begin
            run(k[0], 2 + ($urandom % 6), 1'($urandom % 2));
        end
        preload();
        wr(16'h0008, 0);
        wr(16'h0010, 5);
        repeat (30) @(negedge clk);
        chk(enc_iss + dec_iss, 0, "no start on zero or unmapped");
        rd(16'h0010, 0);
        $display("test zero count and unmapped done");
        close_out();
    end
endmodule // tb_top
